// File: bench/rtf_top_tb.sv
/*
  Self-checking bench of rtf_top: trigger modes, debounce, delay, fault
  latch, lockout and indicators. Assumes rtf_trigger_src as remote side.
*/
`timescale 1ns/1ps
`include "rtf_defines.svh"
module rtf_top_tb;
  import rtf_pkg::*;
  localparam int TICK = 4;
  localparam int HOLD = 40 * TICK;
  typedef struct packed {
    logic [10:0] ctrl;
    logic [5:0] b; // remote, onboard, override raw, uv, close, led
  } rtf_row_type;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic main_want = 1'b0;
  logic ovr_want = 1'b1;
  logic main_remote_in, override_input_pos, override_input_neg;
  logic onboard_sw_in = 1'b0;
  logic fault_short_in = 1'b0;
  logic [2:0] fault_oc_level = 3'h0;
  logic fault_cb1_in = 1'b0;
  logic fault_cb2_in = 1'b0;
  logic fault_ot_in = 1'b0;
  logic fault_uv_in = 1'b0;
  logic fault_ov_in = 1'b0;
  logic array_close, led_fault, led_status;
  logic ext_fault_out, ext_fault_oe_n, ext_status_out, ext_status_oe_n;
  logic ext_fault_in, ext_status_in;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  logic [31:0] st;
  rtf_row_type rows [18] = '{
    '{11'h3F0, 6'b101010}, '{11'h3F0, 6'b001000},
    '{11'h3F1, 6'b001010}, '{11'h3F1, 6'b101000},
    '{11'h3F2, 6'b011010}, '{11'h3F2, 6'b101000},
    '{11'h3F3, 6'b111010}, '{11'h3F3, 6'b101000},
    '{11'h3F3, 6'b011000}, '{11'h3F4, 6'b011010},
    '{11'h3F4, 6'b111000}, '{11'h3F0, 6'b101101},
    '{11'h3F0, 6'b100111}, '{11'h3F8, 6'b101111},
    '{11'h3F0, 6'b000101}, '{11'h2F0, 6'b101100},
    '{11'h3B0, 6'b101110}, '{11'h1F0, 6'b101010}};

  // open-drain pins with pull-ups
  assign ext_fault_in = ext_fault_oe_n ? 1'b1 : ext_fault_out;
  assign ext_status_in = ext_status_oe_n ? 1'b1 : ext_status_out;

  initial begin
    forever #2.5 clock = ~clock;
  end

  rtf_top #(.TICK_CYCLES(TICK), .LOCKOUT_TICKS(200)) rtf_top_i (
    .clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .main_remote_in, .onboard_sw_in, .override_input_pos,
    .override_input_neg, .fault_short_in, .fault_oc_level, .fault_cb1_in,
    .fault_cb2_in, .fault_ot_in, .fault_uv_in, .fault_ov_in, .array_close,
    .led_fault, .led_status, .ext_fault_in, .ext_fault_out,
    .ext_fault_oe_n, .ext_status_in, .ext_status_out, .ext_status_oe_n);

  rtf_trigger_src #(.HOLD_CYCLES(HOLD)) rtf_trigger_src_i (
    .clock, .main_want, .ovr_want, .main_remote_in, .override_input_pos,
    .override_input_neg);

  task automatic chk1(input string what, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic chk32(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wait_cyc(input int c);
    repeat (c) @(posedge clock);
  endtask

  task automatic await(ref logic s, input logic v, input int lim);
    int k;
    k = 0;
    while (s !== v && k < lim) begin
      @(posedge clock);
      k++;
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask

  task automatic count_rises(input int lim, output int cnt);
    logic prev;
    cnt = 0;
    prev = led_fault;
    repeat (lim) begin
      @(posedge clock);
      if (led_fault === 1'b1 && prev === 1'b0) cnt++;
      prev = led_fault;
    end
  endtask

  // retoggle of the remote main trigger
  task automatic toggle_main;
    main_want <= 1'b0;
    await(main_remote_in, 1'b0, HOLD + 8);
    main_want <= 1'b1;
    await(main_remote_in, 1'b1, HOLD + 8);
  endtask

  task automatic summarize;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    chk1("array_close", 1'b0, array_close);
    chk1("ext_fault_oe_n", 1'b1, ext_fault_oe_n);
    chk1("ext_fault_out", 1'b0, ext_fault_out);
    chk1("ext_status_out", 1'b0, ext_status_out);
    reg_read(`RTF_ADDR_CTRL, st);
    chk32("ctrl", 32'h000003E0, st);
    reg_read(`RTF_ADDR_DELAY, st);
    chk32("delay", 32'h00000000, st);
    reg_write(4'hC, 32'hFFFFFFFF);
    reg_read(4'hC, st);
    chk32("unmapped", 32'h00000000, st);
    // debounced remote trigger
    main_want <= 1'b1;
    await(main_remote_in, 1'b1, HOLD + 8);
    wait_cyc(30 * TICK);
    chk1("array_close", 1'b0, array_close);
    await(array_close, 1'b1, 20 * TICK);
    chk1("array_close", 1'b1, array_close);
    // bypassed debounce, then added delay of 5 steps
    reg_write(`RTF_ADDR_CTRL, 32'h000003F0);
    main_want <= 1'b0;
    await(main_remote_in, 1'b0, HOLD + 8);
    wait_cyc(4);
    chk1("array_close", 1'b0, array_close);
    reg_write(`RTF_ADDR_DELAY, 32'h00000005);
    main_want <= 1'b1;
    await(main_remote_in, 1'b1, HOLD + 8);
    wait_cyc(30);
    chk1("array_close", 1'b0, array_close);
    await(array_close, 1'b1, 40);
    chk1("array_close", 1'b1, array_close);
    reg_write(`RTF_ADDR_DELAY, 32'h00000000);
    wait_cyc(1);
    foreach (rows[i]) begin
      reg_write(`RTF_ADDR_CTRL, {21'h000000, rows[i].ctrl});
      main_want <= rows[i].b[5];
      onboard_sw_in <= rows[i].b[4];
      ovr_want <= rows[i].b[3];
      fault_uv_in <= rows[i].b[2];
      wait_cyc(400);
      chk1("array_close", rows[i].b[1], array_close);
      chk1("led_fault", rows[i].b[0], led_fault);
      chk1("led_status", rows[i].b[1] & rows[i].ctrl[9], led_status);
      chk1("ext_fault_oe_n", ~rows[i].b[0], ext_fault_oe_n);
      chk1("ext_status_oe_n", ~(rows[i].b[1] & rows[i].ctrl[9]),
           ext_status_oe_n);
    end
    // short circuit: seven-blink sets, latch and lockout status
    reg_write(`RTF_ADDR_CTRL, 32'h000003F0);
    main_want <= 1'b1;
    ovr_want <= 1'b1;
    fault_uv_in <= 1'b0;
    wait_cyc(400);
    fault_short_in <= 1'b1;
    count_rises(18000, n);
    chk32("short blinks", 32'h00000007, n);
    chk1("array_close", 1'b0, array_close);
    reg_read(`RTF_ADDR_STATUS, st);
    // lockout only runs once the trip inputs have gone quiet
    chk32("status", 32'h00000E06, st & 32'h00000E07);
    fault_short_in <= 1'b0;
    toggle_main();
    await(array_close, 1'b1, 900);
    chk1("array_close", 1'b1, array_close);
    // over-current level 3: retoggle inside lockout waits for its end
    fault_oc_level <= 3'h3;
    wait_cyc(4);
    fault_oc_level <= 3'h0;
    reg_read(`RTF_ADDR_STATUS, st);
    chk32("status", 32'h00000606, st & 32'h00000E07);
    toggle_main();
    wait_cyc(200);
    chk1("array_close", 1'b0, array_close);
    await(array_close, 1'b1, 900);
    chk1("array_close", 1'b1, array_close);
    // on-board switch toggle clears a latched shutdown
    reg_write(`RTF_ADDR_CTRL, 32'h000003F2);
    onboard_sw_in <= 1'b1;
    wait_cyc(HOLD);
    fault_short_in <= 1'b1;
    wait_cyc(4);
    fault_short_in <= 1'b0;
    wait_cyc(900);
    chk1("array_close", 1'b0, array_close);
    onboard_sw_in <= 1'b0;
    wait_cyc(HOLD);
    onboard_sw_in <= 1'b1;
    await(array_close, 1'b1, 40);
    chk1("array_close", 1'b1, array_close);
    // over-temperature under a latched short, then alone
    reg_write(`RTF_ADDR_CTRL, 32'h000003F0);
    fault_ot_in <= 1'b1;
    fault_short_in <= 1'b1;
    wait_cyc(4);
    fault_short_in <= 1'b0;
    wait_cyc(900);
    toggle_main();
    wait_cyc(10);
    chk1("array_close", 1'b0, array_close);
    count_rises(2400, n);
    chk32("temp blinks", 32'h00000002, n);
    fault_ot_in <= 1'b0;
    await(array_close, 1'b1, 20);
    chk1("array_close", 1'b1, array_close);
    summarize();
  end
endmodule

// File: bench/rtf_trigger_src.sv
/*
  Remote trigger sources: the main trigger line and the override switch.
  Assumes the bench clock; every new level stands at least HOLD_CYCLES.
*/
`timescale 1ns/1ps
module rtf_trigger_src #(
  parameter int HOLD_CYCLES = 160
) (
  input wire logic clock, // system clock
  input wire logic main_want, // requested main trigger level
  input wire logic ovr_want, // requested override raw level
  output logic main_remote_in, // main trigger line
  output logic override_input_pos, // override wire
  output logic override_input_neg // override return, tied low
);
  int main_age = 0;
  int ovr_age = 0;
  initial begin
    main_remote_in = 1'b0;
    override_input_pos = 1'b1;
  end
  // override switch between the two wires; raw level rides on pos
  assign override_input_neg = 1'b0;
  // a request waits until the previous level has stood its time
  always @(posedge clock) begin
    main_age <= main_age + 1;
    ovr_age <= ovr_age + 1;
    if (main_want !== main_remote_in && main_age >= HOLD_CYCLES) begin
      main_remote_in <= main_want;
      main_age <= 0;
    end
    if (ovr_want !== override_input_pos && ovr_age >= HOLD_CYCLES) begin
      override_input_pos <= ovr_want;
      ovr_age <= 0;
    end
  end
endmodule

// File: common/rtf_blink_if.sv
/*
  Link between the relay control logic and the fault pattern generator.
  Assumes both ends run on the same clock; tick is a one-cycle 1 ms pulse.
*/
`timescale 1ns/1ps
interface rtf_blink_if;
  import rtf_pkg::*;
  logic tick;
  rtf_pat_type pat;
  logic [2:0] blinks;
  logic lamp;
  modport ctl (output tick, output pat, output blinks, input lamp);
  modport gen (input tick, input pat, input blinks, output lamp);
endinterface

// File: common/rtf_defines.svh
/*
  Constants of the relay trigger and fault indicator block: register map,
  control field positions, reset values, trigger modes and timing figures.
  Assumes a 200 MHz system clock; all long times count 1 ms ticks.
*/
`ifndef RTF_DEFINES_SVH
`define RTF_DEFINES_SVH

// register map (byte addresses)
`define RTF_ADDR_CTRL 4'h0
`define RTF_ADDR_DELAY 4'h4
`define RTF_ADDR_STATUS 4'h8

// control register fields
`define RTF_CTRL_W 11
`define RTF_CTRL_MODE_LSB 0
`define RTF_CTRL_MODE_MSB 2
`define RTF_CTRL_OVR_HI 3
`define RTF_CTRL_BYPASS 4
`define RTF_CTRL_CB_EN 5
`define RTF_CTRL_UV_EN 6
`define RTF_CTRL_OV_EN 7
`define RTF_CTRL_FLED_EN 8
`define RTF_CTRL_SLED_EN 9
`define RTF_CTRL_RETRY 10
`define RTF_CTRL_RESET 11'h3E0
`define RTF_DELAY_W 16
`define RTF_DELAY_RESET 16'h0000

// main trigger configurations
`define RTF_MAIN_REM_HI 3'h0
`define RTF_MAIN_REM_LO 3'h1
`define RTF_MAIN_OB 3'h2
`define RTF_MAIN_OB_HI 3'h3
`define RTF_MAIN_OB_LO 3'h4

// timing
`define RTF_CLK_KHZ 200000
`define RTF_TICK_MS 1
`define RTF_TICK_W 18
`define RTF_DEBOUNCE_MS 40
`define RTF_DELAY_STEP_MS 2
`define RTF_LOCKOUT_S 10
`define RTF_MS_PER_S 1000
`define RTF_SET_HALF_MS 250
`define RTF_SET_DARK_MS 2000
`define RTF_CB2_HALF_MS 500
`define RTF_CB1_HALF_MS 1000
`define RTF_OT_HALF_MS 125
`define RTF_SC_BLINKS 3'h7
`define RTF_MS_W 11

`endif

// File: common/rtf_pkg.sv
/*
  Types of the relay trigger and fault indicator block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rtf_pkg;

  typedef enum logic [2:0] {
    RTF_PAT_OFF = 3'h0,
    RTF_PAT_STEADY = 3'h1,
    RTF_PAT_OT = 3'h2,
    RTF_PAT_CB1 = 3'h3,
    RTF_PAT_CB2 = 3'h4,
    RTF_PAT_SET = 3'h5
  } rtf_pat_type;

  typedef enum logic [1:0] {
    RTF_PH_IDLE = 2'h0,
    RTF_PH_ON = 2'h1,
    RTF_PH_OFF = 2'h3,
    RTF_PH_DARK = 2'h2
  } rtf_phase_type;

endpackage

// File: rtl/rtf_blink.sv
/*
  Fault indicator pattern generator: steady, continuous blink or counted
  blink sets with a dark gap. Assumes a 1 ms tick and a pattern that is
  held stable by the caller; a pattern change restarts the sequence.
*/
`timescale 1ns/1ps
`include "rtf_defines.svh"
module rtf_blink
  import rtf_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic sys_rst, // synchronous reset, active high
  rtf_blink_if.gen bl // pattern request and lamp
);

  rtf_phase_type ph_reg, ph_next;
  logic [`RTF_MS_W-1:0] cnt_reg, cnt_next;
  logic [2:0] n_reg, n_next;
  rtf_pat_type last_reg, last_next;
  logic [`RTF_MS_W-1:0] half;

  function automatic logic [`RTF_MS_W-1:0] half_ms(input rtf_pat_type p);
    case (p)
      RTF_PAT_SET: half_ms = `RTF_MS_W'(`RTF_SET_HALF_MS / `RTF_TICK_MS);
      RTF_PAT_CB2: half_ms = `RTF_MS_W'(`RTF_CB2_HALF_MS / `RTF_TICK_MS);
      RTF_PAT_CB1: half_ms = `RTF_MS_W'(`RTF_CB1_HALF_MS / `RTF_TICK_MS);
      RTF_PAT_OT: half_ms = `RTF_MS_W'(`RTF_OT_HALF_MS / `RTF_TICK_MS);
      default: half_ms = `RTF_MS_W'(1);
    endcase
  endfunction

  always_comb begin
    half = half_ms(bl.pat);
    ph_next = ph_reg;
    cnt_next = cnt_reg;
    n_next = n_reg;
    last_next = bl.pat;
    if (bl.pat != last_reg) begin
      ph_next = (bl.pat == RTF_PAT_OFF || bl.pat == RTF_PAT_STEADY) ?
                RTF_PH_IDLE : RTF_PH_ON;
      cnt_next = '0;
      n_next = '0;
    end else if (bl.tick) begin
      cnt_next = cnt_reg + `RTF_MS_W'(1);
      unique case (ph_reg)
        RTF_PH_IDLE: cnt_next = '0;
        RTF_PH_ON: begin
          if (cnt_reg == half - `RTF_MS_W'(1)) begin
            ph_next = RTF_PH_OFF;
            cnt_next = '0;
          end
        end
        RTF_PH_OFF: begin
          if (cnt_reg == half - `RTF_MS_W'(1)) begin
            cnt_next = '0;
            ph_next = RTF_PH_ON;
            // counted sets end in a dark gap [R3]
            if (bl.pat == RTF_PAT_SET) begin
              n_next = n_reg + 3'h1;
              if (n_reg + 3'h1 >= bl.blinks) begin
                ph_next = RTF_PH_DARK;
                n_next = '0;
              end
            end
          end
        end
        RTF_PH_DARK: begin
          if (cnt_reg == `RTF_MS_W'(`RTF_SET_DARK_MS / `RTF_TICK_MS - 1)) begin
            ph_next = RTF_PH_ON;
            cnt_next = '0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ph_reg <= RTF_PH_IDLE;
      cnt_reg <= '0;
      n_reg <= '0;
      last_reg <= RTF_PAT_OFF;
    end else begin
      ph_reg <= ph_next;
      cnt_reg <= cnt_next;
      n_reg <= n_next;
      last_reg <= last_next;
    end
  end

  // steady for voltage faults, blink phases otherwise [R4]
  assign bl.lamp = (last_reg == RTF_PAT_STEADY) || (ph_reg == RTF_PH_ON);

  a_steady_lamp_on: assert property ( // [R4]
    @(posedge clock) disable iff (sys_rst)
    bl.pat == RTF_PAT_STEADY |=> bl.lamp)
    else $error("steady pattern did not light the lamp");

  a_dark_after_set: assert property ( // [R3]
    @(posedge clock) disable iff (sys_rst)
    ph_reg == RTF_PH_DARK |-> !bl.lamp && last_reg == RTF_PAT_SET)
    else $error("dark gap outside a counted set or lamp lit");

endmodule

// File: rtl/rtf_top.sv
/*
  Relay trigger qualification, switch array command and fault indicators.
  Assumes fault detectors deliver synchronous levels, trigger pins are
  synchronous to clock, and software uses the plain register port.
*/
// The plain strobed port and the placing of the registers were chosen for this implementation.
// How it works
// R1: external outputs mirror every on-board indicator
// R2: disabled on-board indicator also silences external
// R3: short 7 blinks, over-current N, 2 s gap
// R4: slow/fast blink, steady voltage, priority ranks
// R5: five selectable main trigger configurations
// R6: on-board switch opens array, toggle resets; remote-only modes 0 and 1 ignore the switch
// R7: active trigger closes array unless faults
// R8: current fault re-arms after trigger retoggle
// R9: override closes through voltage fault with main
// R10: override polarity selectable, active-low default
// R11: triggers debounced, change must persist 40 ms
// R12: extra trigger delay in 2 ms steps
// R13: debounce may be bypassed
// R14: shutdown reset refused during 10 s lockout
// R15: lower fault pattern resumes after higher clears
// R16: over-temperature keeps tracking triggers
// R17: combined modes need both sources active
`timescale 1ns/1ps
`include "rtf_defines.svh"
module rtf_top
  import rtf_pkg::*;
#(
  parameter int TICK_CYCLES = `RTF_CLK_KHZ * `RTF_TICK_MS,
  parameter int LOCKOUT_TICKS = `RTF_LOCKOUT_S * `RTF_MS_PER_S / `RTF_TICK_MS
) (
  input wire logic clock, // system clock, 200 MHz
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic [3:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  input wire logic main_remote_in, // remote main trigger level
  input wire logic onboard_sw_in, // on-board switch, high = on
  input wire logic override_input_pos, // override trigger wire
  input wire logic override_input_neg, // override trigger return
  input wire logic fault_short_in, // short-circuit detected
  input wire logic [2:0] fault_oc_level, // over-current level, 0 = none
  input wire logic fault_cb1_in, // circuit-break level 1
  input wire logic fault_cb2_in, // circuit-break level 2
  input wire logic fault_ot_in, // over-temperature
  input wire logic fault_uv_in, // under-voltage
  input wire logic fault_ov_in, // over-voltage
  output logic array_close, // switch array command, high = closed
  output logic led_fault, // on-board red fault indicator
  output logic led_status, // on-board array-closed indicator
  input wire logic ext_fault_in, // external fault pin level
  output logic ext_fault_out, // external fault pin drive value
  output logic ext_fault_oe_n, // external fault pin enable, low drives
  input wire logic ext_status_in, // external status pin level
  output logic ext_status_out, // external status pin drive value
  output logic ext_status_oe_n // external status pin enable, low drives
);

  localparam logic [5:0] DB_LAST = 6'(`RTF_DEBOUNCE_MS / `RTF_TICK_MS - 1);
  localparam logic [16:0] STEP_TICKS =
    17'(`RTF_DELAY_STEP_MS / `RTF_TICK_MS);
  localparam logic [13:0] LOCK_LAST = 14'(LOCKOUT_TICKS - 1);
  localparam logic [`RTF_TICK_W-1:0] TICK_LAST =
    `RTF_TICK_W'(TICK_CYCLES - 1);

  rtf_blink_if bl ();

  // decode of the main trigger configuration [R5]
  function automatic logic main_active(input logic [2:0] m,
                                       input logic r, input logic ob);
    case (m)
      `RTF_MAIN_REM_HI: main_active = r;
      `RTF_MAIN_REM_LO: main_active = !r;
      `RTF_MAIN_OB: main_active = ob;
      `RTF_MAIN_OB_HI: main_active = ob && r; // [R17]
      `RTF_MAIN_OB_LO: main_active = ob && !r; // [R17]
      default: main_active = 1'b0;
    endcase
  endfunction

  function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
    hit = (a == b);
  endfunction

  // ---------------- registers
  logic [`RTF_CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [`RTF_DELAY_W-1:0] delay_reg, delay_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] status_word;
  logic [2:0] mode;
  logic ovr_hi, bypass, cb_en, uv_en, ov_en, fled_en, sled_en, retry;

  assign mode = ctrl_reg[`RTF_CTRL_MODE_MSB:`RTF_CTRL_MODE_LSB];
  assign ovr_hi = ctrl_reg[`RTF_CTRL_OVR_HI];
  assign bypass = ctrl_reg[`RTF_CTRL_BYPASS];
  assign cb_en = ctrl_reg[`RTF_CTRL_CB_EN];
  assign uv_en = ctrl_reg[`RTF_CTRL_UV_EN];
  assign ov_en = ctrl_reg[`RTF_CTRL_OV_EN];
  assign fled_en = ctrl_reg[`RTF_CTRL_FLED_EN];
  assign sled_en = ctrl_reg[`RTF_CTRL_SLED_EN];
  assign retry = ctrl_reg[`RTF_CTRL_RETRY];

  always_comb begin
    ctrl_next = ctrl_reg;
    delay_next = delay_reg;
    rdata_next = '0;
    if (reg_wr && hit(reg_addr, `RTF_ADDR_CTRL))
      ctrl_next = reg_wdata[`RTF_CTRL_W-1:0];
    if (reg_wr && hit(reg_addr, `RTF_ADDR_DELAY))
      delay_next = reg_wdata[`RTF_DELAY_W-1:0];
    if (reg_rd) begin
      if (hit(reg_addr, `RTF_ADDR_CTRL))
        rdata_next = {21'h0, ctrl_reg};
      else if (hit(reg_addr, `RTF_ADDR_DELAY))
        rdata_next = {16'h0, delay_reg};
      else if (hit(reg_addr, `RTF_ADDR_STATUS))
        rdata_next = status_word;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_reg <= `RTF_CTRL_RESET; // override active-low by default [R10]
      delay_reg <= `RTF_DELAY_RESET;
      rdata_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      delay_reg <= delay_next;
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata = rdata_reg;

  // ---------------- 1 ms tick
  logic [`RTF_TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
  logic tick;
  always_comb begin
    tick = (tick_cnt_reg == TICK_LAST);
    tick_cnt_next = tick ? '0 : tick_cnt_reg + `RTF_TICK_W'(1);
  end
  always_ff @(posedge clock) begin
    if (sys_rst)
      tick_cnt_reg <= '0;
    else
      tick_cnt_reg <= tick_cnt_next;
  end

  // ---------------- trigger debounce and delay, 0 = main, 1 = override
  logic [1:0] raw, stable, trig_q;
  logic [16:0] dly_target;
  assign raw[0] = main_active(mode, main_remote_in, onboard_sw_in);
  // override polarity [R10]
  assign raw[1] = (override_input_pos && !override_input_neg) == ovr_hi;
  assign dly_target = 17'({1'b0, delay_reg} * STEP_TICKS);

  for (genvar i = 0; i < 2; i++) begin : g_trig
    logic st_reg, st_next, q_reg, q_next;
    logic [5:0] db_reg, db_next;
    logic [16:0] dc_reg, dc_next;
    always_comb begin
      st_next = st_reg;
      db_next = '0;
      q_next = q_reg;
      dc_next = '0;
      if (bypass) begin
        st_next = raw[i]; // [R13]
      end else if (raw[i] != st_reg) begin
        db_next = db_reg;
        if (tick) begin
          // change counts only after it persisted [R11]
          if (db_reg == DB_LAST)
            st_next = raw[i];
          else
            db_next = db_reg + 6'h1;
        end
      end
      if (st_reg != q_reg) begin
        // programmable response delay [R12]
        if (dly_target == 17'h0) begin
          q_next = st_reg;
        end else begin
          dc_next = dc_reg;
          if (tick) begin
            if (dc_reg == dly_target - 17'h1)
              q_next = st_reg;
            else
              dc_next = dc_reg + 17'h1;
          end
        end
      end
    end
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        st_reg <= 1'b0;
        q_reg <= 1'b0;
        db_reg <= '0;
        dc_reg <= '0;
      end else begin
        st_reg <= st_next;
        q_reg <= q_next;
        db_reg <= db_next;
        dc_reg <= dc_next;
      end
    end
    assign stable[i] = st_reg;
    assign trig_q[i] = q_reg;
  end

  logic main_q, ovr_q;
  assign main_q = trig_q[0];
  assign ovr_q = trig_q[1];

  // ---------------- current-fault shutdown latch
  logic latch_reg, latch_next, low_seen_reg, low_seen_next;
  logic [13:0] lock_reg, lock_next;
  rtf_pat_type kind_reg, kind_next;
  logic [2:0] kblk_reg, kblk_next;
  logic trip, lock_done, cb_act, volt_act;

  assign cb_act = cb_en && (fault_cb1_in || fault_cb2_in);
  assign trip = fault_short_in || (fault_oc_level != 3'h0) || cb_act;
  assign volt_act = (uv_en && fault_uv_in) || (ov_en && fault_ov_in);
  assign lock_done = (lock_reg == LOCK_LAST);

  always_comb begin
    latch_next = latch_reg;
    low_seen_next = low_seen_reg;
    lock_next = lock_reg;
    kind_next = kind_reg;
    kblk_next = kblk_reg;
    if (trip) begin
      // a new trip wins over any reset in the same cycle
      latch_next = 1'b1;
      low_seen_next = 1'b0;
      if (!latch_reg)
        lock_next = '0;
      if (fault_short_in) begin
        kind_next = RTF_PAT_SET;
        kblk_next = `RTF_SC_BLINKS; // [R3]
      end else if (fault_oc_level != 3'h0) begin
        kind_next = RTF_PAT_SET;
        kblk_next = fault_oc_level; // [R3]
      end else if (fault_cb2_in) begin
        kind_next = RTF_PAT_CB2;
      end else begin
        kind_next = RTF_PAT_CB1;
      end
    end else if (latch_reg) begin
      if (tick && !lock_done)
        lock_next = lock_reg + 14'h1; // [R14]
      if (!main_q)
        low_seen_next = 1'b1;
      // retoggle or retry, never before lockout ends [R6] [R8] [R14]
      if (lock_done && ((low_seen_reg && main_q) || retry))
        latch_next = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      latch_reg <= 1'b0;
      low_seen_reg <= 1'b0;
      lock_reg <= '0;
      kind_reg <= RTF_PAT_OFF;
      kblk_reg <= '0;
    end else begin
      latch_reg <= latch_next;
      low_seen_reg <= low_seen_next;
      lock_reg <= lock_next;
      kind_reg <= kind_next;
      kblk_reg <= kblk_next;
    end
  end

  // ---------------- array command and indicators
  logic close_reg, close_next, fled_reg, fled_next, sled_reg, sled_next;
  always_comb begin
    // tracks triggers live, so over-temperature exit follows them [R16]
    close_next = main_q && !latch_reg && !trip && !fault_ot_in && // [R7]
                 (!volt_act || ovr_q); // [R9]
    // highest ranked active pattern, lower one resumes [R4] [R15]
    if (latch_reg) begin
      bl.pat = kind_reg;
    end else if (fault_ot_in) begin
      bl.pat = RTF_PAT_OT;
    end else if (volt_act) begin
      bl.pat = RTF_PAT_STEADY;
    end else begin
      bl.pat = RTF_PAT_OFF;
    end
    bl.blinks = kblk_reg;
    bl.tick = tick;
    fled_next = fled_en && bl.lamp; // [R2]
    sled_next = sled_en && close_reg; // [R2]
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      close_reg <= 1'b0;
      fled_reg <= 1'b0;
      sled_reg <= 1'b0;
    end else begin
      close_reg <= close_next;
      fled_reg <= fled_next;
      sled_reg <= sled_next;
    end
  end

  rtf_blink u_blink (
    .clock(clock),
    .sys_rst(sys_rst),
    .bl(bl.gen)
  );

  assign array_close = close_reg;
  assign led_fault = fled_reg;
  assign led_status = sled_reg;
  // open-drain mirrors pull low while the on-board indicator is lit [R1]
  assign ext_fault_out = 1'b0;
  assign ext_fault_oe_n = !fled_reg;
  assign ext_status_out = 1'b0;
  assign ext_status_oe_n = !sled_reg;

  assign status_word = {20'h0, kblk_reg, kind_reg[0], ext_status_in,
                        ext_fault_in, fled_reg, ovr_q, main_q,
                        latch_reg && !lock_done, latch_reg, close_reg};

  // ---------------- checks
  default clocking cb_chk @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_new_trip;
    !latch_reg && trip;
  endsequence
  sequence s_override_path;
    main_q && ovr_q && volt_act && !trip && !latch_reg && !fault_ot_in;
  endsequence

  a_close_needs_main: assert property (close_reg |-> $past(main_q)) // [R7]
    else $error("array closed without active main trigger");
  a_trip_opens: assert property ( // [R7]
    s_new_trip |=> latch_reg ##1 !close_reg)
    else $error("trip did not latch and open array");
  a_lockout_holds: assert property (latch_reg && !lock_done && !trip // [R14]
    |=> latch_reg)
    else $error("shutdown reset during lockout");
  a_override_close: assert property (s_override_path |=> close_reg) // [R9]
    else $error("override did not close through voltage fault");
  a_sc_seven: assert property ((s_new_trip and fault_short_in) // [R3]
    |=> kblk_reg == `RTF_SC_BLINKS && kind_reg == RTF_PAT_SET)
    else $error("short circuit not shown as seven blink sets");
  a_ot_rank: assert property (!latch_reg && fault_ot_in // [R4]
    |-> bl.pat == RTF_PAT_OT)
    else $error("over-temperature not above voltage pattern");
  a_ext_disabled: assert property (!fled_en |=> ext_fault_oe_n) // [R2]
    else $error("external fault driven while disabled");
  a_ext_mirror: assert property (fled_reg |-> !ext_fault_oe_n && // [R1]
    !ext_fault_out)
    else $error("external fault pin does not mirror indicator");
  a_debounce_hold: assert property (!bypass && !tick && // [R11]
    raw[0] != stable[0] |=> $stable(stable[0]))
    else $error("trigger accepted before debounce time");
  a_bypass_direct: assert property (bypass |=> stable == $past(raw)) // [R13]
    else $error("debounce bypass not immediate");

endmodule
